// [ppc_pkg.sv]
// Package for the power path control block: register map, fields, reset values, timing
package ppc_pkg;

  localparam int CLK_MHZ = 125;
  // Interrupt pulse width in microseconds and its cycle count
  localparam int IRQ_PULSE_US = 256;
  localparam int IRQ_PULSE_CYC = IRQ_PULSE_US * CLK_MHZ;
  // Sweep step dwell time in microseconds
  localparam int STEP_DWELL_US = 100;
  localparam int STEP_DWELL_CYC = STEP_DWELL_US * CLK_MHZ;
  // Open-circuit measurement time in microseconds
  localparam int VOC_MEAS_US = 50;
  localparam int VOC_MEAS_CYC = VOC_MEAS_US * CLK_MHZ;
  // Sweep repeat intervals in milliseconds, indexed by the two-bit field
  localparam int SWEEP_MS_0 = 1;
  localparam int SWEEP_MS_1 = 10;
  localparam int SWEEP_MS_2 = 100;
  localparam int SWEEP_MS_3 = 1000;
  localparam longint SWEEP_CYC_0 = longint'(SWEEP_MS_0) * CLK_MHZ * 1000;
  localparam longint SWEEP_CYC_1 = longint'(SWEEP_MS_1) * CLK_MHZ * 1000;
  localparam longint SWEEP_CYC_2 = longint'(SWEEP_MS_2) * CLK_MHZ * 1000;
  localparam longint SWEEP_CYC_3 = longint'(SWEEP_MS_3) * CLK_MHZ * 1000;

  // Input current code: 1 A + code * 125 mA, 2 mOhm sense; 0..392
  localparam logic [8:0] ICL_MAX_CODE = 9'h188;
  localparam logic [8:0] ICL_RESET = ICL_MAX_CODE;
  // Input voltage floor code in mV-like steps; minimum code after reset
  localparam logic [11:0] VFLOOR_MIN_CODE = 12'h000;
  localparam logic [11:0] VFLOOR_RESET = VFLOOR_MIN_CODE;
  localparam logic [11:0] SWEEP_STEP = 12'h010;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ICL = 8'h04;
  localparam logic [7:0] OFS_VFLOOR = 8'h08;
  localparam logic [7:0] OFS_REV_V = 8'h0c;
  localparam logic [7:0] OFS_REV_I = 8'h10;
  localparam logic [7:0] OFS_REV_DIS = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_FLAG = 8'h1c;
  localparam logic [7:0] OFS_MPP = 8'h20;

  // Control register fields
  localparam int CTL_PIN_EN = 0;
  localparam int CTL_MPPT_EN = 1;
  localparam int CTL_SWEEP_NOW = 2;
  localparam int CTL_SWP_LO = 3;
  localparam int CTL_BATI_DIS = 5;
  localparam int CTL_REV_EN = 6;
  localparam int CTL_CHG_EN = 7;
  localparam int CTL_ICL_MASK = 8;
  localparam logic [8:0] CTRL_RESET = 9'h081;

  // Status and flag fields
  localparam int ST_ICL_REG = 0;
  localparam int ST_VFL_REG = 1;
  localparam int ST_REV_ACT = 2;
  localparam int ST_BATT_ONLY = 3;
  localparam int ST_HIZ = 4;
  localparam int ST_SWEEP = 5;

  typedef struct packed {
    logic ibus_over_pin;   // Current-limit pin above its regulation reference
    logic pin_high;        // Current-limit pin above logic-high threshold
    logic ibus_over_reg;   // Input current above register limit
    logic vin_under_floor; // Input below effective floor
    logic vin_under_uv;    // Input below undervoltage reference
    logic vin_valid;       // Input valid for forward operation
    logic vbat_ok;         // Battery sense above 3 V
    logic drv_ok;          // Gate driver supply in window
    logic therm_ok;        // Thermistor inside reverse thresholds
    logic reverse_discharge_limit_over;   // Discharge current above reverse limit
  } ppc_sense_t;

  typedef struct packed {
    logic input_switch;
    logic battery_switch;
    logic converter_on;
    logic reduce_charge;
    logic reduce_reverse;
    logic reverse_mode;
    logic high_impedance_input_mode;
  } ppc_drive_t;

  typedef enum logic [4:0] {
    SW_IDLE = 5'b00001,
    SW_VOC = 5'b00010,
    SW_STEP = 5'b00100,
    SW_DONE = 5'b01000,
    SW_WAIT = 5'b10000
  } ppc_sweep_t;

endpackage : ppc_pkg

// [ppc_power_path.sv]
// Power path control: input limiting, battery-only fallback, sweep and reverse mode
`timescale 1ns/1ps
module ppc_power_path
  import ppc_pkg::*;
(
  input wire logic clk,                 // 125 MHz clock
  input wire logic rstn,                // Async reset, active low
  input wire logic psel,                // APB select
  input wire logic penable,             // APB enable
  input wire logic pwrite,              // APB direction
  input wire logic [7:0] paddr,         // APB byte address
  input wire logic [31:0] pwdata,       // APB write data
  output logic [31:0] prdata,           // APB read data
  output logic pready,                  // APB ready
  output logic pslverr,                 // APB error on unmapped address
  input wire ppc_sense_t sense_pin,     // Comparator results from the analog side
  input wire logic [8:0] pin_limit_code,  // Pin-derived current limit code
  input wire logic [11:0] uv_pin_code,    // Undervoltage pin falling threshold code
  input wire logic [15:0] charge_current, // Charge current from converter, same clock
  input wire logic charge_at_zero,      // Charge current reduced to zero, same clock
  output ppc_drive_t drive,             // Power stage controls
  output logic [8:0] icl_eff,           // Effective input current limit code
  output logic [11:0] vreg_target,      // Input voltage regulation target
  output logic [11:0] rev_v_out,        // Reverse output voltage setting
  output logic [11:0] rev_i_out,        // Reverse output current limit
  output logic bat_i_conv_dis,          // Battery current conversion disable
  output logic irq_n                    // Interrupt pulse, active low
);

  // Three-stage synchroniser on the comparator inputs
  ppc_sense_t s1_q, s2_q, s3_q, sns_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      sns_q <= '0;
    end else begin
      s1_q <= sense_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      sns_q <= (s2_q == s3_q) ? s2_q : sns_q;
    end
  end

  // Registers
  logic [8:0] ctrl_q, ctrl_d;
  logic [8:0] icl_q;
  logic [11:0] vfl_q, revv_q, revi_q, revd_q, mpp_q;
  logic [5:0] flag_q, flag_d, stat_prev_q;
  wire [5:0] stat_w;

  wire pin_en = ctrl_q[CTL_PIN_EN];
  wire mppt_en = ctrl_q[CTL_MPPT_EN];
  wire rev_en = ctrl_q[CTL_REV_EN];
  wire chg_en = ctrl_q[CTL_CHG_EN];

  // APB decode; zero-wait answer
  wire wr = psel && penable && pwrite;
  wire rd = psel && penable && !pwrite;
  wire hit_ctrl = paddr == OFS_CTRL;
  wire hit_icl = paddr == OFS_ICL;
  wire hit_vfl = paddr == OFS_VFLOOR;
  wire hit_revv = paddr == OFS_REV_V;
  wire hit_revi = paddr == OFS_REV_I;
  wire hit_revd = paddr == OFS_REV_DIS;
  wire hit_st = paddr == OFS_STATUS;
  wire hit_fl = paddr == OFS_FLAG;
  wire hit_mpp = paddr == OFS_MPP;
  wire mapped = hit_ctrl | hit_icl | hit_vfl | hit_revv | hit_revi | hit_revd
              | hit_st | hit_fl | hit_mpp;

  // Limit written code to the 50 A top
  wire [8:0] icl_wr = (pwdata[8:0] > ICL_MAX_CODE) ? ICL_MAX_CODE : pwdata[8:0];

  // Current-limit pin functions gated by the enable bit; the undervoltage pin floor is not
  wire pin_over = pin_en && sns_q.ibus_over_pin;
  wire pin_hiz = pin_en && sns_q.pin_high;
  wire [8:0] icl_sel = (pin_en && pin_limit_code < icl_q) ? pin_limit_code : icl_q;
  wire [11:0] vfl_eff = (uv_pin_code > vfl_q) ? uv_pin_code : vfl_q;

  // Sweep machine
  ppc_sweep_t sw_q, sw_d;
  logic [31:0] tmr_q, tmr_d;
  logic [11:0] swv_q, swv_d, best_v_q, best_v_d;
  logic [15:0] best_i_q, best_i_d;
  logic mpp_valid_q, mpp_valid_d;

  wire sweep_req = mppt_en && ctrl_q[CTL_SWEEP_NOW];
  wire [1:0] swp_sel = ctrl_q[CTL_SWP_LO +: 2];
  wire [31:0] wait_cyc = (swp_sel == 2'd0) ? 32'(SWEEP_CYC_0)
                       : (swp_sel == 2'd1) ? 32'(SWEEP_CYC_1)
                       : (swp_sel == 2'd2) ? 32'(SWEEP_CYC_2) : 32'(SWEEP_CYC_3);
  wire tmr_done = tmr_q == 32'h0;
  wire sweep_done = sw_q == SW_DONE;
  wire sweep_hiz = sw_q == SW_VOC;

  always_comb begin
    sw_d = sw_q;
    tmr_d = (tmr_q != 32'h0) ? tmr_q - 32'h1 : tmr_q;
    swv_d = swv_q;
    best_v_d = best_v_q;
    best_i_d = best_i_q;
    mpp_valid_d = mpp_valid_q;
    unique case (sw_q)
      SW_IDLE: begin
        if (mppt_en) begin
          sw_d = SW_VOC;
          tmr_d = 32'(VOC_MEAS_CYC);
        end
      end
      SW_VOC: begin
        if (tmr_done) begin
          sw_d = SW_STEP;
          swv_d = 12'hfff;
          best_i_d = 16'h0;
          best_v_d = 12'hfff;
          tmr_d = 32'(STEP_DWELL_CYC);
        end
      end
      SW_STEP: begin
        if (tmr_done) begin
          if (charge_current >= best_i_d) begin
            best_i_d = charge_current;
            best_v_d = swv_q;
          end
          if (swv_q <= vfl_q + SWEEP_STEP) begin
            sw_d = SW_DONE;
          end else begin
            swv_d = swv_q - SWEEP_STEP;
            tmr_d = 32'(STEP_DWELL_CYC);
          end
        end
      end
      SW_DONE: begin
        mpp_valid_d = 1'b1;
        sw_d = SW_WAIT;
        tmr_d = wait_cyc;
      end
      SW_WAIT: begin
        if (tmr_done || sweep_req) begin
          sw_d = SW_VOC;
          tmr_d = 32'(VOC_MEAS_CYC);
        end
      end
      default: sw_d = SW_IDLE;
    endcase
    if (!mppt_en) begin
      sw_d = SW_IDLE;
      mpp_valid_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sw_q <= SW_IDLE;
      tmr_q <= 32'h0;
      swv_q <= 12'h0;
      best_v_q <= 12'h0;
      best_i_q <= 16'h0;
      mpp_valid_q <= 1'b0;
    end else begin
      sw_q <= sw_d;
      tmr_q <= tmr_d;
      swv_q <= swv_d;
      best_v_q <= best_v_d;
      best_i_q <= best_i_d;
      mpp_valid_q <= mpp_valid_d;
    end
  end

  // Input limiting and battery-only fallback
  wire sweeping = sw_q == SW_STEP;
  wire [11:0] vreg_d = sweeping ? swv_q : (mpp_valid_q ? mpp_q : vfl_eff);
  wire icl_over = pin_over || sns_q.ibus_over_reg;
  wire vfl_under = sns_q.vin_under_floor;
  wire throttle = icl_over || vfl_under;
  wire batt_only = charge_at_zero && sns_q.vin_under_uv;
  wire hiz_d = pin_hiz || sweep_hiz;

  // Reverse mode qualification
  wire rev_allowed = sns_q.vbat_ok && sns_q.drv_ok && !sns_q.vin_valid && rev_en
                   && sns_q.therm_ok;
  // Leaving reverse because the thermistor drifts out also drops the enable
  wire rev_clear = sns_q.vin_valid || (rev_en && !sns_q.therm_ok);

  // Status and sticky flags; flags set on rising edge, set beats read clear
  assign stat_w = {sw_q != SW_IDLE && sw_q != SW_WAIT, hiz_d, batt_only, rev_allowed,
                   vfl_under, pin_over};
  wire [5:0] rise_w = stat_w & ~stat_prev_q;
  wire rd_flag = rd && hit_fl;

  always_comb begin
    flag_d = (rd_flag ? 6'h0 : flag_q) | rise_w;
    ctrl_d = ctrl_q;
    if (wr && hit_ctrl) begin
      ctrl_d = pwdata[8:0];
      if (mppt_en || pwdata[CTL_MPPT_EN]) begin
        ctrl_d[CTL_BATI_DIS] = ctrl_q[CTL_BATI_DIS];
      end
    end
    if (sweep_done) begin
      ctrl_d[CTL_SWEEP_NOW] = 1'b0;
    end
    if (!ctrl_d[CTL_MPPT_EN]) begin
      ctrl_d[CTL_SWEEP_NOW] = 1'b0;
    end
    if (rev_clear) begin
      ctrl_d[CTL_REV_EN] = 1'b0;
    end
  end

  // Interrupt event: unmasked pin current-regulation entry or any other rising status
  wire irq_evt = (rise_w[ST_ICL_REG] && !ctrl_q[CTL_ICL_MASK]) || (|rise_w[5:1]);
  logic [15:0] irq_cnt_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= CTRL_RESET;
      icl_q <= ICL_RESET;
      vfl_q <= VFLOOR_RESET;
      revv_q <= 12'h0;
      revi_q <= 12'h0;
      revd_q <= 12'h0;
      mpp_q <= 12'h0;
      flag_q <= 6'h0;
      stat_prev_q <= 6'h0;
      irq_cnt_q <= 16'h0;
    end else begin
      ctrl_q <= ctrl_d;
      if (wr && hit_icl) icl_q <= icl_wr;
      if (wr && hit_vfl) vfl_q <= pwdata[11:0];
      if (wr && hit_revv) revv_q <= pwdata[11:0];
      if (wr && hit_revi) revi_q <= pwdata[11:0];
      if (wr && hit_revd) revd_q <= pwdata[11:0];
      if (sweep_done) mpp_q <= best_v_q;
      flag_q <= flag_d;
      stat_prev_q <= stat_w;
      // A new event restarts the pulse; one pulse per burst of close events
      if (irq_evt) irq_cnt_q <= 16'(IRQ_PULSE_CYC);
      else if (irq_cnt_q != 16'h0) irq_cnt_q <= irq_cnt_q - 16'h1;
    end
  end

  // Read mux
  wire [31:0] rd_mux = hit_ctrl ? {23'h0, ctrl_q}
                     : hit_icl ? {23'h0, icl_q}
                     : hit_vfl ? {20'h0, vfl_q}
                     : hit_revv ? {20'h0, revv_q}
                     : hit_revi ? {20'h0, revi_q}
                     : hit_revd ? {20'h0, revd_q}
                     : hit_st ? {26'h0, stat_w}
                     : hit_fl ? {26'h0, flag_q}
                     : hit_mpp ? {20'h0, mpp_q} : 32'h0;

  // Registered outputs
  wire rev_act = rev_allowed && !rev_clear;
  ppc_drive_t drive_d;
  always_comb begin
    drive_d.reverse_mode = rev_act;
    drive_d.input_switch = !rev_act && sns_q.vin_valid && !hiz_d && !batt_only;
    drive_d.battery_switch = !rev_act;
    drive_d.converter_on = rev_act
                         || (sns_q.vin_valid && chg_en && !hiz_d && !batt_only);
    drive_d.reduce_charge = throttle && !rev_act;
    drive_d.reduce_reverse = rev_act && sns_q.reverse_discharge_limit_over;
    drive_d.high_impedance_input_mode = hiz_d;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      drive <= '0;
      icl_eff <= ICL_RESET;
      vreg_target <= VFLOOR_RESET;
      rev_v_out <= 12'h0;
      rev_i_out <= 12'h0;
      bat_i_conv_dis <= 1'b0;
      irq_n <= 1'b1;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
      drive <= drive_d;
      icl_eff <= icl_sel;
      vreg_target <= vreg_d;
      rev_v_out <= revv_q;
      rev_i_out <= revi_q;
      bat_i_conv_dis <= ctrl_q[CTL_BATI_DIS] && !mppt_en;
      irq_n <= !(irq_evt || irq_cnt_q > 16'h1);
    end
  end

endmodule : ppc_power_path

// [ppc_power_path_sva.sv]
// Port checker for the power path control block
`timescale 1ns/1ps
module ppc_power_path_sva
  import ppc_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rstn, // Reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic [31:0] prdata, // APB read data
  input wire ppc_sense_t sense_pin, // Comparators
  input wire logic charge_at_zero, // Charge at zero
  input wire ppc_drive_t drive, // Power stage
  input wire logic [8:0] icl_eff, // Current limit
  input wire logic irq_n // Interrupt
);
  logic [15:0] low_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Merged pulses run longer, so only a lower bound on the width holds
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_q <= 16'h0000;
    end else if (irq_n) begin
      low_q <= 16'h0000;
    end else begin
      low_q <= low_q + 16'h0001;
    end
  end
  chk_apb_answer: assert property (psel && !penable |=> pready)
    else $error("No ready after setup");
  chk_ready_access: assert property (pready |-> psel && penable && $past(psel && !penable))
    else $error("Ready outside access");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("Error without ready");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("Read data outside access");
  chk_icl_range: assert property (icl_eff <= ICL_MAX_CODE)
    else $error("Current limit above top code");
  chk_rev_switches: assert property (drive.reverse_mode
    |-> !drive.input_switch && !drive.battery_switch)
    else $error("Switch on in reverse");
  chk_rev_battery: assert property (!sense_pin.vbat_ok [*8] |-> !drive.reverse_mode)
    else $error("Reverse on weak battery");
  chk_rev_input: assert property (sense_pin.vin_valid [*8] |-> !drive.reverse_mode)
    else $error("Reverse with valid input");
  chk_over_throttle: assert property (sense_pin.ibus_over_reg [*8] |-> drive.reduce_charge)
    else $error("Overload without throttle");
  chk_uv_stop: assert property ((sense_pin.vin_under_uv && charge_at_zero) [*8]
    |-> !drive.converter_on || drive.reverse_mode)
    else $error("Converter runs on collapsed input");
  chk_irq_width: assert property ($rose(irq_n) |-> low_q >= IRQ_PULSE_CYC)
    else $error("Interrupt pulse too short");
  cover property ($fell(irq_n));
  cover property (drive.reverse_mode && drive.reduce_reverse);
  cover property (drive.high_impedance_input_mode);
  cover property (pslverr);
endmodule : ppc_power_path_sva

bind ppc_power_path ppc_power_path_sva chk_u (.clk(clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .sense_pin(sense_pin), .charge_at_zero(charge_at_zero), .drive(drive),
  .icl_eff(icl_eff), .irq_n(irq_n));

// [ppc_power_path_test.sv]
// Self-checking bench for the power path control block
`timescale 1ns/1ps
module ppc_power_path_test
  import ppc_pkg::*;
;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, starve, st_n;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  ppc_sense_t env, e_n, sense_pin;
  ppc_drive_t drive;
  logic [8:0] pin_limit_code, pin_n, icl_eff;
  logic [11:0] uv_pin_code, uv_n, vreg_target, rev_v_out, rev_i_out;
  logic [15:0] charge_current;
  logic charge_at_zero, bat_i_conv_dis, irq_n;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;

  ppc_source_model #(.PEAK_V(12'hfef)) src_u (.env(env), .starve(starve), .drive(drive),
    .vreg_target(vreg_target), .sense_pin(sense_pin), .charge_current(charge_current),
    .charge_at_zero(charge_at_zero));
  ppc_power_path dut_u (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sense_pin(sense_pin), .pin_limit_code(pin_limit_code),
    .uv_pin_code(uv_pin_code), .charge_current(charge_current),
    .charge_at_zero(charge_at_zero), .drive(drive), .icl_eff(icl_eff),
    .vreg_target(vreg_target), .rev_v_out(rev_v_out), .rev_i_out(rev_i_out),
    .bat_i_conv_dis(bat_i_conv_dis), .irq_n(irq_n));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task summarize();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 99000) begin
      bad_count = bad_count + 1;
      $display("Error at %0t: run did not finish", $time);
      summarize();
    end
  end

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Values read right after the edge are those the edge sampled; only the bench timeout ends this
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task rd_chk(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    checks++;
    if ((r & m) !== x || e !== xe) begin
      bad_count++;
      $display("Error at %0t: read %h gave %h err %b", $time, a, r, e);
    end
  endtask : rd_chk

  task cmp(input logic [31:0] got, input logic [31:0] x);
    checks++;
    if (got !== x) begin
      bad_count++;
      $display("Error at %0t: port %h expected %h", $time, got, x);
    end
  endtask : cmp

  task settle();
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask : settle

  // Source conditions change together on one rising edge
  task put();
    @(posedge clk);
    env <= e_n;
    pin_limit_code <= pin_n;
    uv_pin_code <= uv_n;
    starve <= st_n;
    settle();
  endtask : put

  initial begin
    int i;
    logic [31:0] r;
    logic e;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rstn = 1'b0;
    st_n = 1'b0;
    starve = 1'b0;
    pin_n = 9'h030;
    pin_limit_code = pin_n;
    uv_n = 12'h000;
    uv_pin_code = uv_n;
    e_n = '0;
    e_n.vin_valid = 1'b1;
    env = e_n;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd_chk(OFS_CTRL, 32'h081, 32'hffffffff, 1'b0);
    rd_chk(OFS_ICL, 32'h188, 32'hffffffff, 1'b0);
    rd_chk(OFS_VFLOOR, 32'h0, 32'hffffffff, 1'b0);
    rd_chk(8'h40, 32'h0, 32'hffffffff, 1'b1);
    wr(OFS_ICL, 32'h050);
    settle();
    cmp(32'(icl_eff), 32'h030);
    pin_n = 9'h100;
    put();
    cmp(32'(icl_eff), 32'h050);
    wr(OFS_ICL, 32'h1ff);
    rd_chk(OFS_ICL, 32'h188, 32'hffffffff, 1'b0);
    wr(OFS_CTRL, 32'h080);
    pin_n = 9'h020;
    e_n.pin_high = 1'b1;
    put();
    cmp(32'(icl_eff), 32'h188);
    cmp(32'(drive.high_impedance_input_mode), 32'h0);
    wr(OFS_CTRL, 32'h081);
    settle();
    cmp(32'(drive.high_impedance_input_mode), 32'h1);
    e_n.pin_high = 1'b0;
    wr(OFS_VFLOOR, 32'h200);
    uv_n = 12'h300;
    put();
    cmp(32'(vreg_target), 32'h300);
    uv_n = 12'h100;
    put();
    cmp(32'(vreg_target), 32'h200);
    e_n.ibus_over_reg = 1'b1;
    put();
    cmp(32'(drive.reduce_charge), 32'h1);
    e_n.ibus_over_reg = 1'b0;
    put();
    cmp(32'(drive.reduce_charge), 32'h0);
    e_n.vin_under_uv = 1'b1;
    st_n = 1'b1;
    put();
    cmp(32'(drive.converter_on), 32'h0);
    rd_chk(OFS_STATUS, 32'h8, 32'h8, 1'b0);
    e_n.vin_under_uv = 1'b0;
    st_n = 1'b0;
    rd_chk(OFS_FLAG, 32'h18, 32'h18, 1'b0);
    e_n.ibus_over_pin = 1'b1;
    put();
    rd_chk(OFS_STATUS, 32'h1, 32'h1, 1'b0);
    cmp(32'(irq_n), 32'h0);
    rd_chk(OFS_FLAG, 32'h1, 32'h1, 1'b0);
    rd_chk(OFS_FLAG, 32'h0, 32'h1, 1'b0);
    e_n.ibus_over_pin = 1'b0;
    wr(OFS_CTRL, 32'h181);
    put();
    rd_chk(OFS_FLAG, 32'h0, 32'h3f, 1'b0);
    for (i = 0; i < 40000 && irq_n !== 1'b1; i++) begin
      @(posedge clk);
    end
    e_n.ibus_over_pin = 1'b1;
    put();
    rd_chk(OFS_FLAG, 32'h1, 32'h1, 1'b0);
    cmp(32'(irq_n), 32'h1);
    e_n = '0;
    e_n.vbat_ok = 1'b1;
    e_n.drv_ok = 1'b1;
    e_n.therm_ok = 1'b1;
    put();
    wr(OFS_CTRL, 32'h041);
    settle();
    cmp(32'(drive.reverse_mode), 32'h1);
    cmp({drive.input_switch, drive.battery_switch}, 32'h0);
    rd_chk(OFS_STATUS, 32'h4, 32'h4, 1'b0);
    wr(OFS_REV_V, 32'h123);
    settle();
    cmp(32'(rev_v_out), 32'h123);
    wr(OFS_REV_I, 32'h0ab);
    settle();
    cmp(32'(rev_i_out), 32'h0ab);
    e_n.reverse_discharge_limit_over = 1'b1;
    put();
    cmp(32'(drive.reduce_reverse), 32'h1);
    wr(OFS_CTRL, 32'h001);
    settle();
    cmp({drive.reverse_mode, drive.battery_switch, drive.converter_on}, 32'h2);
    e_n.vbat_ok = 1'b0;
    put();
    wr(OFS_CTRL, 32'h041);
    settle();
    cmp(32'(drive.reverse_mode), 32'h0);
    e_n.vbat_ok = 1'b1;
    put();
    cmp(32'(drive.reverse_mode), 32'h1);
    e_n.vin_valid = 1'b1;
    put();
    rd_chk(OFS_CTRL, 32'h0, 32'h40, 1'b0);
    cmp(32'(drive.input_switch), 32'h1);
    wr(OFS_VFLOOR, 32'hfc0);
    wr(OFS_CTRL, 32'h0a7);
    settle();
    cmp(32'(bat_i_conv_dis), 32'h0);
    cmp(32'(drive.high_impedance_input_mode), 32'h1);
    repeat (VOC_MEAS_CYC + STEP_DWELL_CYC / 2) @(posedge clk);
    @(negedge clk);
    cmp(32'(vreg_target), 32'hfff);
    repeat (STEP_DWELL_CYC) @(posedge clk);
    @(negedge clk);
    cmp(32'(vreg_target), 32'hfef);
    r = 32'hffffffff;
    for (i = 0; i < 100 && r[ST_SWEEP] !== 1'b0; i++) begin
      repeat (1000) @(posedge clk);
      apb(1'b0, OFS_STATUS, 32'h0, r, e);
    end
    rd_chk(OFS_MPP, 32'hfef, 32'hfff, 1'b0);
    rd_chk(OFS_CTRL, 32'h0, 32'h4, 1'b0);
    settle();
    cmp(32'(vreg_target), 32'hfef);
    summarize();
  end
endmodule : ppc_power_path_test

// [ppc_source_model.sv]
// Behavioural model of the input source, battery and load
`timescale 1ns/1ps
module ppc_source_model
  import ppc_pkg::*;
#(
  parameter logic [11:0] PEAK_V = 12'hfef // Voltage of highest charge
)(
  input wire ppc_sense_t env, // Levels asked for by the bench
  input wire logic starve, // Source gives no charge at all
  input wire ppc_drive_t drive, // Power stage controls
  input wire logic [11:0] vreg_target, // Input regulation target
  output ppc_sense_t sense_pin, // Comparator results
  output logic [15:0] charge_current, // Charge current
  output logic charge_at_zero // Charge at zero
);
  // An open input draws nothing, so over-current drops in high impedance
  always_comb begin
    sense_pin = env;
    if (drive.high_impedance_input_mode) begin
      sense_pin.ibus_over_pin = 1'b0;
      sense_pin.ibus_over_reg = 1'b0;
    end
  end
  // One sharp peak gives the sweep a single right answer
  assign charge_current = starve ? 16'h0000 : (vreg_target == PEAK_V) ? 16'h0800 : 16'h0400;
  assign charge_at_zero = (charge_current == 16'h0000);
endmodule : ppc_source_model
